// ### peripheral_irq_enable_priority_tb.sv
// Self-checking bench for the peripheral interrupt enable and priority block.
// Assumes pirqep_top answers APB with one wait state and has the checker bound.
`timescale 1ns/1ps
`include "pirqep_consts.vh"
module peripheral_irq_enable_priority_tb;
    localparam logic [11:0] a_en2 = `PIRQEP_OFS_ENABLE2;
    localparam logic [11:0] a_pr1 = `PIRQEP_OFS_PRIO1;
    localparam logic [11:0] a_pr2 = `PIRQEP_OFS_PRIO2;
    localparam logic [11:0] a_rc = `PIRQEP_OFS_RESET_CTRL;
    logic clk_in = 1'b0, srst_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [31:0] paddr_in = 32'h0000_0000, pwdata_in = 32'h0000_0000;
    logic [3:0] pstrb_in = 4'hf;
    logic [7:0] flags1_in = 8'h00, enable1_in = 8'h00, flags2_in = 8'h00;
    logic reset_instr_in = 1'b0, wdt_timeout_in = 1'b0, sleep_in = 1'b0;
    logic clrwdt_in = 1'b0, power_on_event_in = 1'b0, brown_out_event_in = 1'b0;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, irq_high_out, irq_low_out, priority_levels_on_out;
    int fail_count = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic e;
    pirqep_top dut_u (.*);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task final_report;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= {20'h0_0000, a};
        pwdata_in <= {24'h00_0000, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            final_report();
        end else begin
            q = prdata_out;
            e = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    task rd(input string n, input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(n, q, {24'h00_0000, x});
        chk("error flag", {31'h0000_0000, e}, 32'h0000_0000);
    endtask
    task irq(input logic [7:0] f1, input logic [7:0] f2, input logic h, input logic l);
        @(posedge clk_in);
        flags1_in <= f1;
        flags2_in <= f2;
        repeat (2) @(posedge clk_in);
        chk("irq_high", {31'h0000_0000, irq_high_out}, {31'h0000_0000, h});
        chk("irq_low", {31'h0000_0000, irq_low_out}, {31'h0000_0000, l});
    endtask
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int p;
        int i;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        rd("enable2", a_en2, 8'h00);
        rd("prio1", a_pr1, 8'hff);
        rd("prio2", a_pr2, 8'hdf);
        rd("reset_control", a_rc, 8'h1c);
        apb(1'b0, 12'h0fc, 8'h00);
        chk("unmapped error", {31'h0000_0000, e}, 32'h0000_0001);
        chk("unmapped data", q, 32'h0000_0000);
        apb(1'b1, a_en2, 8'hff);
        rd("enable2", a_en2, 8'hdf);
        pstrb_in <= 4'he;
        apb(1'b1, a_en2, 8'h00);
        pstrb_in <= 4'hf;
        rd("enable2 lane off", a_en2, 8'hdf);
        apb(1'b1, a_pr1, 8'hda);
        rd("prio1", a_pr1, 8'hda);
        apb(1'b1, a_pr2, 8'hff);
        rd("prio2", a_pr2, 8'hdf);
        apb(1'b1, a_pr2, 8'h00);
        rd("prio2", a_pr2, 8'h00);
        irq(8'h00, 8'h20, 1'b0, 1'b0);
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 8; i++) begin
                if (i != 5) begin
                    apb(1'b1, a_en2, ~(8'h01 << i));
                    irq(8'h00, 8'h01 << i, 1'b0, 1'b0);
                    apb(1'b1, a_en2, 8'h01 << i);
                    irq(8'h00, 8'h01 << i, p == 0, p == 1);
                end
            end
            if (p == 0) begin
                apb(1'b1, a_rc, 8'h90);
                rd("reset_control", a_rc, 8'h9c);
                chk("levels on", {31'h0000_0000, priority_levels_on_out}, 32'h0000_0001);
            end
        end
        apb(1'b1, a_pr2, 8'h80);
        irq(8'h00, 8'h80, 1'b1, 1'b0);
        enable1_in <= 8'h03;
        irq(8'h01, 8'h00, 1'b0, 1'b1);
        irq(8'h02, 8'h00, 1'b1, 1'b0);
        sleep_in <= 1'b1;
        @(posedge clk_in);
        sleep_in <= 1'b0;
        rd("reset_control", a_rc, 8'h98);
        wdt_timeout_in <= 1'b1;
        @(posedge clk_in);
        wdt_timeout_in <= 1'b0;
        rd("reset_control", a_rc, 8'h90);
        apb(1'b1, a_rc, 8'hff);
        rd("reset_control", a_rc, 8'h93);
        clrwdt_in <= 1'b1;
        reset_instr_in <= 1'b1;
        power_on_event_in <= 1'b1;
        brown_out_event_in <= 1'b1;
        @(posedge clk_in);
        clrwdt_in <= 1'b0;
        reset_instr_in <= 1'b0;
        power_on_event_in <= 1'b0;
        brown_out_event_in <= 1'b0;
        rd("reset_control", a_rc, 8'h8c);
        apb(1'b1, a_rc, 8'h00);
        irq(8'h01, 8'h00, 1'b1, 1'b0);
        chk("levels on", {31'h0000_0000, priority_levels_on_out}, 32'h0000_0000);
        final_report();
    end
endmodule

// ### pirqep_chk.sv
// Assertion checker for the peripheral interrupt enable and priority block.
// Assumes it is bound to pirqep_top and sees only that module's ports.
`timescale 1ns/1ps
`include "pirqep_consts.vh"
module pirqep_chk (
    input wire clk_in,
    input wire srst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] paddr_in,
    input wire [7:0] flags1_in,
    input wire [7:0] flags2_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire irq_high_out,
    input wire irq_low_out,
    input wire priority_levels_on_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire rd_ok = pready_out && !pwrite_in;
    wire [11:0] a = paddr_in[11:0];
    // ----------------------------------------
    // Bus answer and read data
    // ----------------------------------------
    chk_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready did not follow the first access cycle");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready stood longer than one cycle");
    chk_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error flagged without ready");
    chk_upper_zero: assert property (rd_ok |-> prdata_out[31:8] == 24'h00_0000)
        else $error("read data above the byte lane not zero");
    chk_bit5_zero: assert property (rd_ok && (a == `PIRQEP_OFS_ENABLE2 ||
        a == `PIRQEP_OFS_PRIO2) |-> !prdata_out[5])
        else $error("unused bit 5 read as one");
    chk_ctrl_bits: assert property (rd_ok && a == `PIRQEP_OFS_RESET_CTRL
        |-> prdata_out[6:5] == 2'h0 && prdata_out[7] == priority_levels_on_out)
        else $error("reset control read disagrees with level output");
    // ----------------------------------------
    // Request lines
    // ----------------------------------------
    chk_legacy_no_low: assert property (!priority_levels_on_out
        && !$past(priority_levels_on_out) |-> !irq_low_out)
        else $error("low request raised in legacy mode");
    chk_idle_quiet: assert property ($past(flags1_in) == 8'h00
        && $past(flags2_in) == 8'h00 |-> !irq_high_out && !irq_low_out)
        else $error("request raised with no flag set");
    chk_unused_quiet: assert property ($past(flags1_in) == 8'h00
        && $past(flags2_in) == 8'h20 |-> !irq_high_out && !irq_low_out)
        else $error("request raised by the unused flag");
    cover property (pslverr_out);
    cover property (irq_high_out);
    cover property (irq_low_out);
endmodule
bind pirqep_top pirqep_chk chk_u (.*);

// ### pirqep_consts.vh
// Constants for the peripheral interrupt enable and priority block.
// Assumes an APB master with 32-bit data and a single 200 MHz clock.

`ifndef PIRQEP_CONSTS_VH
`define PIRQEP_CONSTS_VH

`define PIRQEP_ADDR_W 12
`define PIRQEP_OFS_ENABLE2 12'h004
`define PIRQEP_OFS_PRIO1 12'h008
`define PIRQEP_OFS_PRIO2 12'h00C
`define PIRQEP_OFS_RESET_CTRL 12'h010

`define PIRQEP_SEL_NONE 3'h0
`define PIRQEP_SEL_ENABLE2 3'h1
`define PIRQEP_SEL_PRIO1 3'h2
`define PIRQEP_SEL_PRIO2 3'h3
`define PIRQEP_SEL_RESET_CTRL 3'h4

`define PIRQEP_ENABLE2_MASK 8'hDF
`define PIRQEP_ENABLE2_RST 8'h00
`define PIRQEP_PRIO1_MASK 8'hFF
`define PIRQEP_PRIO1_RST 8'hFF
`define PIRQEP_PRIO2_MASK 8'hDF
`define PIRQEP_PRIO2_RST 8'hDF

`define PIRQEP_RC_PRIO_ON 7
`define PIRQEP_RC_RESET_INSTR 4
`define PIRQEP_RC_WDT 3
`define PIRQEP_RC_POWER_DOWN 2
`define PIRQEP_RC_POWER_ON 1
`define PIRQEP_RC_BROWN_OUT 0
`define PIRQEP_RC_PRIO_ON_RST 1'b0
`define PIRQEP_RC_RESET_INSTR_RST 1'b1
`define PIRQEP_RC_WDT_RST 1'b1
`define PIRQEP_RC_POWER_DOWN_RST 1'b1
`define PIRQEP_RC_POWER_ON_RST 1'b0
`define PIRQEP_RC_BROWN_OUT_RST 1'b0

`define PIRQEP_SOURCES 16
`define PIRQEP_BYTE_W 8

`define PIRQEP_G2_OSC_FAIL 7
`define PIRQEP_G2_COMPARATOR 6
`define PIRQEP_G2_NV_WRITE 4
`define PIRQEP_G2_BUS_COLL 3
`define PIRQEP_G2_LOW_VOLT 2
`define PIRQEP_G2_TIMER3 1
`define PIRQEP_G2_CAPCOMP2 0
`define PIRQEP_G1_PARALLEL 7
`define PIRQEP_G1_ADC 6
`define PIRQEP_G1_SERIAL_RX 5
`define PIRQEP_G1_SERIAL_TX 4
`define PIRQEP_G1_SYNC_SERIAL 3
`define PIRQEP_G1_CAPCOMP1 2
`define PIRQEP_G1_TIMER2 1
`define PIRQEP_G1_TIMER1 0

`endif

// ### pirqep_top.v
// Peripheral interrupt enable, priority and reset control registers.
// Assumes flags and the first enable register come from logic on clk_in.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "pirqep_consts.vh"

module pirqep_top (
    input wire clk_in,
    input wire srst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire [7:0] flags1_in,
    input wire [7:0] enable1_in,
    input wire [7:0] flags2_in,
    input wire reset_instr_in,
    input wire wdt_timeout_in,
    input wire sleep_in,
    input wire clrwdt_in,
    input wire power_on_event_in,
    input wire brown_out_event_in,
    output wire irq_high_out,
    output wire irq_low_out,
    output wire priority_levels_on_out
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    function [2:0] pirqep_decode;
        input [31:0] addr;
        begin
            if (addr[31:`PIRQEP_ADDR_W] != {(32 - `PIRQEP_ADDR_W){1'b0}}) begin
                pirqep_decode = `PIRQEP_SEL_NONE;
            end else begin
                case (addr[`PIRQEP_ADDR_W-1:0])
                    `PIRQEP_OFS_ENABLE2: pirqep_decode = `PIRQEP_SEL_ENABLE2;
                    `PIRQEP_OFS_PRIO1: pirqep_decode = `PIRQEP_SEL_PRIO1;
                    `PIRQEP_OFS_PRIO2: pirqep_decode = `PIRQEP_SEL_PRIO2;
                    `PIRQEP_OFS_RESET_CTRL: pirqep_decode = `PIRQEP_SEL_RESET_CTRL;
                    default: pirqep_decode = `PIRQEP_SEL_NONE;
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------

    reg pready_q;
    reg pready_d;
    reg pslverr_q;
    reg pslverr_d;
    reg [31:0] prdata_q;
    reg [31:0] prdata_d;

    wire access_wait;
    wire commit_write;
    wire [2:0] sel;
    wire low_lane;

    assign access_wait = psel_in & penable_in & ~pready_q;
    assign sel = pirqep_decode(paddr_in);
    assign low_lane = pstrb_in[0];
    assign commit_write = psel_in & penable_in & pready_q & pwrite_in &
                          low_lane & (sel != `PIRQEP_SEL_NONE);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------

    reg [7:0] enable2_q;
    reg [7:0] enable2_d;
    reg [7:0] prio1_q;
    reg [7:0] prio1_d;
    reg [7:0] prio2_q;
    reg [7:0] prio2_d;
    reg prio_on_q;
    reg prio_on_d;
    reg reset_instr_q;
    reg reset_instr_d;
    reg wdt_q;
    reg wdt_d;
    reg power_down_q;
    reg power_down_d;
    reg power_on_q;
    reg power_on_d;
    reg brown_out_q;
    reg brown_out_d;

    wire [7:0] wbyte;
    wire [7:0] reset_ctrl_rd;

    assign wbyte = pwdata_in[`PIRQEP_BYTE_W-1:0];
    assign reset_ctrl_rd = {prio_on_q, 2'b00, reset_instr_q, wdt_q,
                            power_down_q, power_on_q, brown_out_q};

    always @* begin
        enable2_d = enable2_q;
        prio1_d = prio1_q;
        prio2_d = prio2_q;
        prio_on_d = prio_on_q;
        reset_instr_d = reset_instr_q;
        wdt_d = wdt_q;
        power_down_d = power_down_q;
        power_on_d = power_on_q;
        brown_out_d = brown_out_q;
        if (commit_write) begin
            case (sel)
                `PIRQEP_SEL_ENABLE2: begin
                    enable2_d = wbyte & `PIRQEP_ENABLE2_MASK;
                end
                `PIRQEP_SEL_PRIO1: begin
                    prio1_d = wbyte & `PIRQEP_PRIO1_MASK;
                end
                `PIRQEP_SEL_PRIO2: begin
                    prio2_d = wbyte & `PIRQEP_PRIO2_MASK;
                end
                `PIRQEP_SEL_RESET_CTRL: begin
                    prio_on_d = wbyte[`PIRQEP_RC_PRIO_ON];
                    reset_instr_d = wbyte[`PIRQEP_RC_RESET_INSTR];
                    power_on_d = wbyte[`PIRQEP_RC_POWER_ON];
                    brown_out_d = wbyte[`PIRQEP_RC_BROWN_OUT];
                end
                default: begin
                    enable2_d = enable2_q;
                end
            endcase
        end
        // Hardware events come last so that they win over a software write.
        if (reset_instr_in) begin
            reset_instr_d = 1'b0;
        end
        if (clrwdt_in) begin
            wdt_d = 1'b1;
            power_down_d = 1'b1;
        end
        if (sleep_in) begin
            wdt_d = 1'b1;
            power_down_d = 1'b0;
        end
        if (wdt_timeout_in) begin
            wdt_d = 1'b0;
        end
        if (power_on_event_in) begin
            power_on_d = 1'b0;
        end
        if (brown_out_event_in) begin
            brown_out_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    always @* begin
        pready_d = access_wait;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (access_wait) begin
            pslverr_d = (sel == `PIRQEP_SEL_NONE);
            prdata_d = 32'h0000_0000;
            if (!pwrite_in) begin
                case (sel)
                    `PIRQEP_SEL_ENABLE2: prdata_d[7:0] = enable2_q;
                    `PIRQEP_SEL_PRIO1: prdata_d[7:0] = prio1_q;
                    `PIRQEP_SEL_PRIO2: prdata_d[7:0] = prio2_q;
                    `PIRQEP_SEL_RESET_CTRL: prdata_d[7:0] = reset_ctrl_rd;
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------------

    wire osc_fail_en;
    wire comparator_en;
    wire nv_write_done_en;
    wire bus_collision_en;
    wire low_voltage_en;
    wire timer3_ovf_en;
    wire capcomp2_en;
    wire osc_fail_prio;
    wire comparator_prio;
    wire nv_write_done_prio;
    wire bus_collision_prio;
    wire low_voltage_prio;
    wire timer3_ovf_prio;
    wire capcomp2_prio;
    wire parallel_slave_prio;
    wire adc_done_prio;
    wire serial_rx_prio;
    wire serial_tx_prio;
    wire sync_serial_prio;
    wire capcomp1_prio;
    wire timer2_match_prio;
    wire timer1_ovf_prio;

    assign osc_fail_en = enable2_q[`PIRQEP_G2_OSC_FAIL];
    assign comparator_en = enable2_q[`PIRQEP_G2_COMPARATOR];
    assign nv_write_done_en = enable2_q[`PIRQEP_G2_NV_WRITE];
    assign bus_collision_en = enable2_q[`PIRQEP_G2_BUS_COLL];
    assign low_voltage_en = enable2_q[`PIRQEP_G2_LOW_VOLT];
    assign timer3_ovf_en = enable2_q[`PIRQEP_G2_TIMER3];
    assign capcomp2_en = enable2_q[`PIRQEP_G2_CAPCOMP2];

    assign osc_fail_prio = prio2_q[`PIRQEP_G2_OSC_FAIL];
    assign comparator_prio = prio2_q[`PIRQEP_G2_COMPARATOR];
    assign nv_write_done_prio = prio2_q[`PIRQEP_G2_NV_WRITE];
    assign bus_collision_prio = prio2_q[`PIRQEP_G2_BUS_COLL];
    assign low_voltage_prio = prio2_q[`PIRQEP_G2_LOW_VOLT];
    assign timer3_ovf_prio = prio2_q[`PIRQEP_G2_TIMER3];
    assign capcomp2_prio = prio2_q[`PIRQEP_G2_CAPCOMP2];
    assign parallel_slave_prio = prio1_q[`PIRQEP_G1_PARALLEL];
    assign adc_done_prio = prio1_q[`PIRQEP_G1_ADC];
    assign serial_rx_prio = prio1_q[`PIRQEP_G1_SERIAL_RX];
    assign serial_tx_prio = prio1_q[`PIRQEP_G1_SERIAL_TX];
    assign sync_serial_prio = prio1_q[`PIRQEP_G1_SYNC_SERIAL];
    assign capcomp1_prio = prio1_q[`PIRQEP_G1_CAPCOMP1];
    assign timer2_match_prio = prio1_q[`PIRQEP_G1_TIMER2];
    assign timer1_ovf_prio = prio1_q[`PIRQEP_G1_TIMER1];

    // ------------------------------------------------------------------
    // Request routing
    // ------------------------------------------------------------------

    wire [`PIRQEP_SOURCES-1:0] flags;
    wire [`PIRQEP_SOURCES-1:0] enables;
    wire [`PIRQEP_SOURCES-1:0] prios;
    wire [`PIRQEP_SOURCES-1:0] want_high;
    wire [`PIRQEP_SOURCES-1:0] want_low;

    assign flags = {flags2_in, flags1_in};
    // The unused slot of the second group is tied low so its flag never counts.
    assign enables = {osc_fail_en, comparator_en, 1'b0, nv_write_done_en, bus_collision_en,
                      low_voltage_en, timer3_ovf_en, capcomp2_en, enable1_in};
    assign prios = {osc_fail_prio, comparator_prio, 1'b0, nv_write_done_prio,
                    bus_collision_prio, low_voltage_prio, timer3_ovf_prio, capcomp2_prio,
                    parallel_slave_prio, adc_done_prio, serial_rx_prio, serial_tx_prio,
                    sync_serial_prio, capcomp1_prio, timer2_match_prio,
                    timer1_ovf_prio};

    genvar gi;
    generate
        for (gi = 0; gi < `PIRQEP_SOURCES; gi = gi + 1) begin : g_src
            wire pending;
            assign pending = flags[gi] & enables[gi];
            // Legacy mode sends every request to the high line.
            assign want_high[gi] = pending & (~prio_on_q | prios[gi]);
            assign want_low[gi] = pending & prio_on_q & ~prios[gi];
        end
    endgenerate

    reg irq_high_q;
    reg irq_high_d;
    reg irq_low_q;
    reg irq_low_d;

    always @* begin
        irq_high_d = |want_high;
        irq_low_d = |want_low;
    end

    // ------------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------------

    always @(posedge clk_in) begin
        if (srst_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            enable2_q <= `PIRQEP_ENABLE2_RST;
            prio1_q <= `PIRQEP_PRIO1_RST;
            prio2_q <= `PIRQEP_PRIO2_RST;
            prio_on_q <= `PIRQEP_RC_PRIO_ON_RST;
            reset_instr_q <= `PIRQEP_RC_RESET_INSTR_RST;
            wdt_q <= `PIRQEP_RC_WDT_RST;
            power_down_q <= `PIRQEP_RC_POWER_DOWN_RST;
            power_on_q <= `PIRQEP_RC_POWER_ON_RST;
            brown_out_q <= `PIRQEP_RC_BROWN_OUT_RST;
            irq_high_q <= 1'b0;
            irq_low_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            enable2_q <= enable2_d;
            prio1_q <= prio1_d;
            prio2_q <= prio2_d;
            prio_on_q <= prio_on_d;
            reset_instr_q <= reset_instr_d;
            wdt_q <= wdt_d;
            power_down_q <= power_down_d;
            power_on_q <= power_on_d;
            brown_out_q <= brown_out_d;
            irq_high_q <= irq_high_d;
            irq_low_q <= irq_low_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign irq_high_out = irq_high_q;
    assign irq_low_out = irq_low_q;
    assign priority_levels_on_out = prio_on_q;

endmodule
